// ### hdl/dsp_fetch_pkg.sv
// constants shared by the fetch front end and its instruction cache
// assumes a 24-bit instruction word with the field layout below
package dsp_fetch_pkg;

    ////////////////////////////////////////////////////////////////////////
    // instruction layout
    localparam int OP_LSB     = 20;
    localparam int OP_W       = 4;
    localparam int AGSEL_BIT  = 19;
    localparam int WR_BIT     = 18;
    localparam int COND_LSB   = 16;
    localparam int COND_W     = 4;
    localparam int CNT_LSB    = 14;
    localparam int CNT_W      = 6;
    localparam int REGSEL_LSB = 16;
    localparam int VALUE_LSB  = 0;

    ////////////////////////////////////////////////////////////////////////
    // opcodes; anything else is a compute op passed to the core
    localparam logic [3:0] OP_NOP     = 4'h0;
    localparam logic [3:0] OP_JUMP    = 4'h1;
    localparam logic [3:0] OP_DO      = 4'h2;
    localparam logic [3:0] OP_DM_RD   = 4'h3;
    localparam logic [3:0] OP_DM_WR   = 4'h4;
    localparam logic [3:0] OP_DM_IND  = 4'h5;
    localparam logic [3:0] OP_PM_IND  = 4'h6;
    localparam logic [3:0] OP_DUAL    = 4'h7;
    localparam logic [3:0] OP_AG_LOAD = 4'h8;

    // register select of an address generator load
    localparam logic [1:0] AGREG_INDEX  = 2'h0;
    localparam logic [1:0] AGREG_MODIFY = 2'h1;
    localparam logic [1:0] AGREG_LENGTH = 2'h2;
    localparam logic [1:0] AGREG_PX     = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [13:0] RESET_PC   = 14'h0000;
    localparam logic [23:0] NOP_WORD   = 24'h000000;
    localparam logic [13:0] RESET_AG   = 14'h0000;
    localparam logic [5:0]  RESET_LOOP = 6'h00;

    typedef enum logic {FETCH_RUN, FETCH_STALL} fetch_state_e;

endpackage

// ### hdl/icache_if.sv
// port bundle between the fetch front end and its instruction cache store
// assumes one clock; the store samples these on its rising edge
`timescale 1ns/1ps
interface icache_if #(
    parameter int WIDTH = 24,
    parameter int IDX_W = 4
) ();
    logic             en;
    logic             wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [WIDTH-1:0] wr_data;
    logic             rd_en;
    logic [IDX_W-1:0] rd_idx;
    logic [WIDTH-1:0] rd_data;

    modport ctrl (output en, wr_en, wr_idx, wr_data, rd_en, rd_idx,
                  input rd_data);
    modport mem  (input en, wr_en, wr_idx, wr_data, rd_en, rd_idx,
                  output rd_data);
endinterface

// ### hdl/icache_mem.sv
// instruction cache store: one write port, one registered read port
// assumes the controller keeps tags and valid bits
`timescale 1ns/1ps
module icache_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 24,
    parameter int IDX_W = 4
) (
    input wire logic i_clock,  // processor clock
    input wire logic i_rst_n,  // synchronised reset, active low
    icache_if.mem    port      // access from the fetch front end
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge i_clock) begin
        if (port.en && port.wr_en) begin
            store[port.wr_idx] <= port.wr_data;
        end
    end

    // same-slot read and write returns the new word
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port.rd_data <= '0;
        end else if (port.en && port.rd_en) begin
            if (port.wr_en && port.wr_idx == port.rd_idx) begin
                port.rd_data <= port.wr_data;
            end else begin
                port.rd_data <= store[port.rd_idx];
            end
        end
    end
endmodule

// ### hdl/dsp_fetch_front.sv
// fetch, cache and memory-bus front end of a 16-bit fixed-point processor
// assumes synchronous external memories answering within the cycle
// Contract
// - drive a 14-bit program address bus reaching 16K code and data.
// - program memory words are 24 bits, the instruction width.
// - drive a 14-bit data memory address reaching 16K words.
// - data memory words are 16 bits; register moves take one cycle.
// - a dedicated output marks program accesses as code or data.
// - fetch into instruction register, execute next cycle; one stage.
// - next address comes from current instruction and status.
// - conditional branch in one cycle; loops with zero overhead.
// - sixteen-entry cache, filled in circular order.
// - every instruction loaded into the register also enters the cache.
// - on program-memory data access a valid cache entry supplies next.
// - without a valid entry the next fetch takes one extra cycle.
// - one data and one program memory operand in the same cycle.
// - data address is absolute from instruction or from a generator.
// - program memory data is addressed only through a generator.
// - first generator addresses data memory; second addresses both.
// - each generator updates linearly or modulo for circular buffers.
// - bus exchange passes words between buses across the 8-bit gap.
// - every instruction completes in a single cycle.
`timescale 1ns/1ps
module dsp_fetch_front #(
    parameter int ADDR_W = 14,
    parameter int WORD_W = 24,
    parameter int DATA_W = 16,
    parameter int DEPTH  = 16
) (
    input  wire logic              i_clock,          // 50 MHz clock
    input  wire logic              i_arst_n,         // async reset, low
    input  wire logic              i_enable,         // clock enable
    input  wire logic [15:0]       i_status,         // processor status
    input  wire logic [DATA_W-1:0] i_core_word,      // register to store
    input  wire logic [WORD_W-1:0] i_program_word_bus, // program data in
    output logic      [ADDR_W-1:0] o_program_addr_bus, // program address
    output logic                   o_program_code_or_data_select, // 1=data
    output logic                   o_program_read,   // program read
    output logic                   o_program_write,  // program write
    output logic      [WORD_W-1:0] o_program_word_out, // program data out
    output logic                   o_program_word_oe, // drive program bus
    input  wire logic [DATA_W-1:0] i_datamem_word_bus, // data mem data in
    output logic      [ADDR_W-1:0] o_datamem_addr,   // data mem address
    output logic                   o_datamem_read,   // data mem read
    output logic                   o_datamem_write,  // data mem write
    output logic      [DATA_W-1:0] o_datamem_word_out, // data mem data out
    output logic                   o_datamem_word_oe, // drive data bus
    output logic      [WORD_W-1:0] o_instr_word,     // instruction register
    output logic                   o_instr_valid,    // not a bubble
    output logic      [DATA_W-1:0] o_dm_operand,     // data mem operand
    output logic      [WORD_W-1:0] o_pm_operand,     // program operand
    output logic      [DATA_W-1:0] o_pm_exchange     // upper part, 16 bits
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam int PX_W  = WORD_W - DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // state
    dsp_fetch_pkg::fetch_state_e state_q;
    dsp_fetch_pkg::fetch_state_e state_d;
    logic              cache_q;
    logic [ADDR_W-1:0] pc_q;
    logic [ADDR_W-1:0] tag_q [DEPTH];
    logic [DEPTH-1:0]  valid_q;
    logic [IDX_W-1:0]  wp_q;
    logic [ADDR_W-1:0] ag_i_q [2];
    logic [ADDR_W-1:0] ag_m_q [2];
    logic [ADDR_W-1:0] ag_l_q [2];
    logic [ADDR_W-1:0] ag_b_q [2];
    logic [PX_W-1:0]   px_q;
    logic              loop_act_q;
    logic [ADDR_W-1:0] loop_start_q;
    logic [ADDR_W-1:0] loop_end_q;
    logic [dsp_fetch_pkg::CNT_W-1:0] loop_cnt_q;

    icache_if #(.WIDTH(WORD_W), .IDX_W(IDX_W)) cache ();

    icache_mem #(.DEPTH(DEPTH), .WIDTH(WORD_W), .IDX_W(IDX_W)) u_cache (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .port    (cache.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode of the word entering the instruction register
    logic [WORD_W-1:0] ir_d;
    logic              bubble;
    logic              from_bus;
    logic [3:0]        op;
    logic [ADDR_W-1:0] field;
    logic              agsel;
    logic              wr_bit;
    logic              uses_pm;
    logic              direct;
    logic [1:0]        ag_use;
    logic              at_loop_end;
    logic [ADDR_W-1:0] next_pc;
    logic [DEPTH-1:0]  slot_hit;
    logic              hit;
    logic [IDX_W-1:0]  hit_idx;

    always_comb begin
        bubble   = (state_q == dsp_fetch_pkg::FETCH_STALL);
        from_bus = !bubble && !cache_q;
        if (bubble) begin
            ir_d = dsp_fetch_pkg::NOP_WORD;
        end else if (cache_q) begin
            ir_d = cache.rd_data;
        end else begin
            ir_d = i_program_word_bus;
        end
    end

    assign op     = ir_d[dsp_fetch_pkg::OP_LSB +: dsp_fetch_pkg::OP_W];
    assign field  = ir_d[dsp_fetch_pkg::VALUE_LSB +: ADDR_W];
    assign agsel  = ir_d[dsp_fetch_pkg::AGSEL_BIT];
    assign wr_bit = ir_d[dsp_fetch_pkg::WR_BIT];
    assign uses_pm = (op == dsp_fetch_pkg::OP_PM_IND)
                  || (op == dsp_fetch_pkg::OP_DUAL);
    assign direct = (op == dsp_fetch_pkg::OP_DM_RD)
                 || (op == dsp_fetch_pkg::OP_DM_WR);
    assign ag_use[0] = (op == dsp_fetch_pkg::OP_DM_IND && !agsel)
                    || (op == dsp_fetch_pkg::OP_DUAL);
    assign ag_use[1] = (op == dsp_fetch_pkg::OP_DM_IND && agsel)
                    || uses_pm;
    assign at_loop_end = loop_act_q && !bubble && (pc_q == loop_end_q);

    always_comb begin
        if (bubble) begin
            next_pc = pc_q;
        end else if (op == dsp_fetch_pkg::OP_JUMP
                     && i_status[ir_d[dsp_fetch_pkg::COND_LSB +:
                                      dsp_fetch_pkg::COND_W]]) begin
            next_pc = field;
        end else if (at_loop_end && loop_cnt_q > 6'h01) begin
            next_pc = loop_start_q;
        end else begin
            next_pc = pc_q + 1'b1;
        end
    end

    // the slot written this edge counts as already holding its word
    for (genvar g = 0; g < DEPTH; g++) begin : gen_tag
        assign slot_hit[g] = (from_bus && wp_q == IDX_W'(g))
                           ? (pc_q == next_pc)
                           : (valid_q[g] && tag_q[g] == next_pc);
    end

    function automatic logic [IDX_W-1:0] first_set(
        input logic [DEPTH-1:0] vec
    );
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int k = DEPTH - 1; k >= 0; k--) begin
            if (vec[k]) begin
                idx = IDX_W'(k);
            end
        end
        return idx;
    endfunction

    assign hit     = |slot_hit;
    assign hit_idx = first_set(slot_hit);
    assign state_d = (uses_pm && !hit) ? dsp_fetch_pkg::FETCH_STALL
                                       : dsp_fetch_pkg::FETCH_RUN;

    ////////////////////////////////////////////////////////////////////////
    // cache control
    assign cache.en      = i_enable;
    assign cache.wr_en   = from_bus;
    assign cache.wr_idx  = wp_q;
    assign cache.wr_data = ir_d;
    assign cache.rd_en   = uses_pm && hit;
    assign cache.rd_idx  = hit_idx;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= '0;
            wp_q    <= '0;
        end else if (i_enable && from_bus) begin
            valid_q[wp_q] <= 1'b1;
            wp_q          <= wp_q + 1'b1;
        end
    end

    // tags need no reset: valid bits guard them
    always_ff @(posedge i_clock) begin
        if (i_enable && from_bus) begin
            tag_q[wp_q] <= pc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and pipeline register
    // one pipeline stage
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= dsp_fetch_pkg::FETCH_STALL;
            cache_q       <= 1'b0;
            pc_q          <= dsp_fetch_pkg::RESET_PC;
            o_instr_word  <= dsp_fetch_pkg::NOP_WORD;
            o_instr_valid <= 1'b0;
        end else if (i_enable) begin
            state_q       <= state_d;
            cache_q       <= uses_pm && hit;
            pc_q          <= next_pc;
            o_instr_word  <= ir_d;
            o_instr_valid <= !bubble;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            loop_act_q   <= 1'b0;
            loop_start_q <= dsp_fetch_pkg::RESET_PC;
            loop_end_q   <= dsp_fetch_pkg::RESET_PC;
            loop_cnt_q   <= dsp_fetch_pkg::RESET_LOOP;
        end else if (i_enable) begin
            if (op == dsp_fetch_pkg::OP_DO) begin
                loop_act_q   <= 1'b1;
                loop_start_q <= pc_q + 1'b1;
                loop_end_q   <= field;
                loop_cnt_q   <= ir_d[dsp_fetch_pkg::CNT_LSB +:
                                     dsp_fetch_pkg::CNT_W];
            end else if (at_loop_end) begin
                if (loop_cnt_q > 6'h01) begin
                    loop_cnt_q <= loop_cnt_q - 1'b1;
                end else begin
                    loop_act_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address generators
    // linear when length is zero, else wrap inside base..base+len-1
    function automatic logic [ADDR_W-1:0] ag_step(
        input logic [ADDR_W-1:0] idx,
        input logic [ADDR_W-1:0] mod,
        input logic [ADDR_W-1:0] len,
        input logic [ADDR_W-1:0] base
    );
        logic signed [ADDR_W+1:0] n;
        logic signed [ADDR_W+1:0] lo;
        logic signed [ADDR_W+1:0] hi;
        logic signed [ADDR_W+1:0] span;
        n    = signed'({2'b00, idx}) + signed'({{2{mod[ADDR_W-1]}}, mod});
        span = signed'({2'b00, len});
        lo   = signed'({2'b00, base});
        hi   = lo + span;
        if (len != '0) begin
            if (n >= hi) begin
                n = n - span;
            end else if (n < lo) begin
                n = n + span;
            end
        end
        return n[ADDR_W-1:0];
    endfunction

    for (genvar g = 0; g < 2; g++) begin : gen_ag
        logic load;
        assign load = (op == dsp_fetch_pkg::OP_AG_LOAD) && (agsel == 1'(g));
        always_ff @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                ag_i_q[g] <= dsp_fetch_pkg::RESET_AG;
                ag_m_q[g] <= dsp_fetch_pkg::RESET_AG;
                ag_l_q[g] <= dsp_fetch_pkg::RESET_AG;
                ag_b_q[g] <= dsp_fetch_pkg::RESET_AG;
            end else if (i_enable) begin
                if (load) begin
                    case (ir_d[dsp_fetch_pkg::REGSEL_LSB +: 2])
                        dsp_fetch_pkg::AGREG_INDEX: begin
                            ag_i_q[g] <= field;
                            ag_b_q[g] <= field;
                        end
                        dsp_fetch_pkg::AGREG_MODIFY: ag_m_q[g] <= field;
                        dsp_fetch_pkg::AGREG_LENGTH: ag_l_q[g] <= field;
                        default: ;
                    endcase
                end else if (ag_use[g]) begin
                    ag_i_q[g] <= ag_step(ag_i_q[g], ag_m_q[g],
                                         ag_l_q[g], ag_b_q[g]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program memory bus, registered from the decode
    // program address
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_program_addr_bus            <= dsp_fetch_pkg::RESET_PC;
            o_program_code_or_data_select <= 1'b0;
            o_program_read                <= 1'b1;
            o_program_write               <= 1'b0;
            o_program_word_out            <= '0;
            o_program_word_oe             <= 1'b0;
        end else if (i_enable) begin
            o_program_addr_bus <= uses_pm ? ag_i_q[1] : next_pc;
            o_program_code_or_data_select <= uses_pm;
            o_program_read  <= !(op == dsp_fetch_pkg::OP_PM_IND && wr_bit);
            o_program_write <= (op == dsp_fetch_pkg::OP_PM_IND && wr_bit);
            // widen with the exchange low byte
            o_program_word_out <= {i_core_word, px_q};
            o_program_word_oe  <= (op == dsp_fetch_pkg::OP_PM_IND && wr_bit);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data memory bus
    // data address
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_datamem_addr     <= '0;
            o_datamem_read     <= 1'b0;
            o_datamem_write    <= 1'b0;
            o_datamem_word_out <= '0;
            o_datamem_word_oe  <= 1'b0;
        end else if (i_enable) begin
            if (direct) begin
                o_datamem_addr <= field;
            end else if (ag_use[0] && !uses_pm) begin
                o_datamem_addr <= ag_i_q[0];
            end else if (op == dsp_fetch_pkg::OP_DUAL) begin
                o_datamem_addr <= ag_i_q[0];
            end else begin
                o_datamem_addr <= ag_i_q[1];
            end
            o_datamem_read <= (op == dsp_fetch_pkg::OP_DM_RD)
                           || (op == dsp_fetch_pkg::OP_DUAL)
                           || (op == dsp_fetch_pkg::OP_DM_IND && !wr_bit);
            o_datamem_write <= (op == dsp_fetch_pkg::OP_DM_WR)
                            || (op == dsp_fetch_pkg::OP_DM_IND && wr_bit);
            o_datamem_word_out <= i_core_word;
            o_datamem_word_oe  <= (op == dsp_fetch_pkg::OP_DM_WR)
                               || (op == dsp_fetch_pkg::OP_DM_IND && wr_bit);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand capture and bus exchange
    // full-width program word
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_dm_operand  <= '0;
            o_pm_operand  <= '0;
            o_pm_exchange <= '0;
            px_q          <= '0;
        end else if (i_enable) begin
            if (o_datamem_read) begin
                o_dm_operand <= i_datamem_word_bus;
            end
            if (o_program_read && o_program_code_or_data_select) begin
                o_pm_operand  <= i_program_word_bus;
                o_pm_exchange <= i_program_word_bus[WORD_W-1 -: DATA_W];
                px_q          <= i_program_word_bus[PX_W-1:0];
            end else if (op == dsp_fetch_pkg::OP_AG_LOAD
                         && ir_d[dsp_fetch_pkg::REGSEL_LSB +: 2]
                            == dsp_fetch_pkg::AGREG_PX) begin
                px_q <= field[PX_W-1:0];
            end
        end
    end

endmodule

// ### test/dsp_fetch_front_sva.sv
// port checks for the fetch front end, bound to its top module
// assumes one clock and the asynchronous active-low reset
`timescale 1ns/1ps
module dsp_fetch_front_sva (
    input wire logic        i_clock, // clock
    input wire logic        i_arst_n, // reset
    input wire logic        i_enable, // advance
    input wire logic [15:0] i_core_word, // store data
    input wire logic [23:0] i_program_word_bus, // pm data
    input wire logic [15:0] i_datamem_word_bus, // dm data
    input wire logic        o_program_code_or_data_select, // 1=data
    input wire logic        o_program_read, // pm read
    input wire logic        o_datamem_read, // dm read
    input wire logic        o_datamem_write, // dm write
    input wire logic [13:0] o_datamem_addr, // dm address
    input wire logic [15:0] o_datamem_word_out, // dm out
    input wire logic [23:0] o_instr_word, // executing
    input wire logic        o_instr_valid, // not bubble
    input wire logic [15:0] o_dm_operand, // dm operand
    input wire logic [23:0] o_pm_operand // pm operand
);
    wire       sel = o_program_code_or_data_select;
    wire [3:0] op  = o_instr_word[23:20];
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////////////
    pm_data_op_a: assert property (
        sel |-> op inside {4'h6, 4'h7}) else $error("pm data off its op");
    wr_data_a: assert property (
        $rose(o_datamem_write) |-> o_datamem_word_out == $past(i_core_word))
        else $error("dm write data wrong");
    dm_direct_a: assert property (
        (o_datamem_read || o_datamem_write) && op inside {4'h3, 4'h4}
        |-> o_datamem_addr == o_instr_word[13:0]) else $error("dm addr");
    bubble_cause_a: assert property (
        $fell(o_instr_valid) |-> $past(sel)) else $error("stray bubble");
    refill_a: assert property (
        $fell(o_instr_valid) && i_enable |=> o_instr_valid)
        else $error("second bubble");
    fetch_load_a: assert property (
        o_instr_valid && !sel && i_enable |=> o_instr_valid
        && o_instr_word == $past(i_program_word_bus)) else $error("fetch");
    dm_capture_a: assert property (
        o_datamem_read && i_enable |=>
        o_dm_operand == $past(i_datamem_word_bus)) else $error("dm operand");
    pm_capture_a: assert property (
        sel && o_program_read && i_enable |=>
        o_pm_operand == $past(i_program_word_bus)) else $error("pm operand");
endmodule

bind dsp_fetch_front dsp_fetch_front_sva u_sva (.*);

// ### test/mem_partner.sv
// program and data memories facing the fetch front end
// assumes reads answer within the cycle; writes land on the rising edge
`timescale 1ns/1ps
module mem_partner (
    input  wire logic        i_clock, // clock
    input  wire logic [13:0] i_p_addr, // pm address
    input  wire logic        i_p_read, // pm read
    input  wire logic        i_p_write, // pm write
    input  wire logic [23:0] i_p_wdata, // pm write data
    output logic      [23:0] o_p_data, // pm read data
    input  wire logic [13:0] i_d_addr, // dm address
    input  wire logic        i_d_read, // dm read
    input  wire logic        i_d_write, // dm write
    input  wire logic [15:0] i_d_wdata, // dm write data
    output logic      [15:0] o_d_data // dm read data
);
    logic [23:0] mem_p [16384];
    logic [15:0] mem_d [16384];
    logic [23:0] last_p = 24'h000000;
    logic [15:0] last_d = 16'h0000;
    // words carry their address so a wrong pointer shows at once
    initial begin
        for (int a = 0; a < 16384; a++) begin
            mem_p[a] = {10'h2a5, 14'(a)};
            mem_d[a] = {2'h1, 14'(a)};
        end
    end
    // idle bus toggles instead of holding a stale word
    assign o_p_data = i_p_read ? mem_p[i_p_addr] : ~last_p;
    assign o_d_data = i_d_read ? mem_d[i_d_addr] : ~last_d;
    always @(posedge i_clock) begin
        last_p <= o_p_data;
        last_d <= o_d_data;
        if (i_p_write) mem_p[i_p_addr] <= i_p_wdata;
        if (i_d_write) mem_d[i_d_addr] <= i_d_wdata;
    end
endmodule

// ### test/tb.sv
// bench for the fetch front end: a fixed program against its expected
// instruction stream; assumes mem_partner holds both memories
`timescale 1ns/1ps
module tb;
    logic        i_clock, i_arst_n, i_enable, o_program_code_or_data_select;
    logic        o_program_read, o_program_write, o_program_word_oe;
    logic        o_datamem_read, o_datamem_write, o_datamem_word_oe;
    logic        o_instr_valid;
    logic [13:0] o_program_addr_bus, o_datamem_addr;
    logic [15:0] i_status, i_core_word, i_datamem_word_bus, o_pm_exchange;
    logic [15:0] o_datamem_word_out, o_dm_operand, wr;
    logic [23:0] i_program_word_bus, o_program_word_out, o_instr_word;
    logic [23:0] o_pm_operand, cur, prv;
    logic [7:0]  px;
    logic        pm, pw;
    int          seed = 96614;
    int          num_errors, n_compared, e, g1, g2, ln;
    // loads, dm write and read, pm read, jump, pm write, looped dual, park
    logic [23:0] prog [15] = '{24'h800010, 24'h810001, 24'h880123,
        24'h890001, 24'h400020, 24'h300020, 24'h600000, 24'h130009, 24'h0,
        24'h640000, 24'h20c00c, 24'h700000, 24'h820002, 24'h140000,
        24'h13000e};
    // program addresses in load order, -1 for a bubble
    int          exp_q [$] = '{-1, 0, 1, 2, 3, 4, 5, 6, -1, 7, 9, -1, 10, 11,
        -1, 12, 11, 12, 11, 12, 13, 14, 14};

    dsp_fetch_front u_dut (.*);
    mem_partner u_mem (.i_clock(i_clock), .i_p_addr(o_program_addr_bus),
        .i_p_read(o_program_read), .i_p_write(o_program_write),
        .i_p_wdata(o_program_word_out), .o_p_data(i_program_word_bus),
        .i_d_addr(o_datamem_addr), .i_d_read(o_datamem_read),
        .i_d_write(o_datamem_write), .i_d_wdata(o_datamem_word_out),
        .o_d_data(i_datamem_word_bus));

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] got, input logic [23:0] want);
        n_compared++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t: %h versus %h", $time, got, want);
        end
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_arst_n = 1'b0;
        i_enable = 1'b0;
        i_status = 16'h0008;
        i_core_word = 16'h0000;
        g1 = 'h10;
        g2 = 'h123;
        ln = 0;
        px = 8'h0;
        prv = 24'h0;
        wr = 16'h0;
        #1;
        for (int a = 0; a < 15; a++) u_mem.mem_p[a] = prog[a];
        repeat (10) @(negedge i_clock);
        i_arst_n = 1'b1;
        repeat (3) @(negedge i_clock);
        for (int k = 0; k < 300 && exp_q.size() > 0; k++) begin
            // status bit 3 high and bit 4 low steer all three jumps
            i_status = 16'($random(seed)) & 16'hffef | 16'h0008;
            i_core_word = 16'($random(seed));
            i_enable = ($random(seed) & 7) != 0;
            @(negedge i_clock);
            if (!i_enable) continue;
            e = exp_q.pop_front();
            cur = (e < 0) ? 24'h0 : prog[e];
            pm = cur[23:21] == 3'h3;
            pw = cur[23:18] == 6'h19;
            chk(o_instr_valid, e >= 0);
            chk(o_instr_word, cur);
            chk(o_program_code_or_data_select, pm);
            chk({o_program_write, o_program_word_oe}, {pw, pw});
            chk(o_datamem_write, cur[23:20] == 4'h4);
            if (pm) chk(o_program_addr_bus, 14'(g2));
            if (pw) chk(o_program_word_out, {i_core_word, px});
            if (prv[23:20] == 4'h3) chk(o_dm_operand, wr);
            if (prv[23:20] == 4'h7) begin
                chk(o_dm_operand, {2'h1, 14'(g1)});
                g1 = g1 + 1;
                // first generator wraps once a length is loaded
                if (ln > 0 && g1 >= 16 + ln) g1 = g1 - ln;
            end
            if (prv[23:21] == 3'h3 && !prv[18]) begin
                chk(o_pm_operand, {10'h2a5, 14'(g2)});
                chk(o_pm_exchange, {10'h2a5, 6'(g2 >> 8)});
                px = 8'(g2);
            end
            if (prv[23:21] == 3'h3) g2 = g2 + 1;
            if (cur[23:16] == 8'h82) ln = int'(cur[13:0]);
            if (cur[23:20] == 4'h4) wr = i_core_word;
            prv = cur;
        end
        if (exp_q.size() > 0) num_errors++;
        end_of_test;
    end
endmodule
